// File: hw/cbs_pkg.sv
// Purpose: shared constants and types for the branch and skip unit
// Assumes: 16-bit word-addressed program counter, 8-bit flag register
// Notes:   flag bit positions follow the core's flag register layout
`default_nettype none

package cbs_pkg;

    // ************************************************************
    // widths and flag positions
    // ************************************************************
    localparam int PC_W   = 16;
    localparam int OFS_W  = 12;
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    localparam logic [7:0]      FLAGS_RST = 8'h00;
    localparam logic [PC_W-1:0] PC_RST    = 16'h0000;

    // ************************************************************
    // cycle counts
    // ************************************************************
    localparam logic [2:0] CYC_ONE     = 3'h1;
    localparam logic [2:0] CYC_FMUL    = 3'h2;
    localparam logic [2:0] CYC_JUMP    = 3'h2;
    localparam logic [2:0] CYC_TAKEN   = 3'h2;
    localparam logic [2:0] CYC_CALL    = 3'h3;
    localparam logic [2:0] CYC_DJUMP   = 3'h3;
    localparam logic [2:0] CYC_DCALL   = 3'h4;
    localparam logic [2:0] CYC_RETURN  = 3'h4;
    localparam logic [2:0] CYC_SKIP1   = 3'h2;
    localparam logic [2:0] CYC_SKIP2   = 3'h3;

    // pc steps past a one-word or two-word instruction, and for a skip over one or two
    localparam logic [PC_W-1:0] PC_STEP   = 16'h0001;
    localparam logic [PC_W-1:0] PC_DSTEP  = 16'h0002;
    localparam logic [PC_W-1:0] PC_SKIP1  = 16'h0002;
    localparam logic [PC_W-1:0] PC_SKIP2  = 16'h0003;

    // ************************************************************
    // operations handed over by the decoder
    // ************************************************************
    typedef enum logic [4:0] {
        OP_FRAC_MULT_SIGNED,
        OP_FRAC_MULT_MIXED,
        OP_RELATIVE_JUMP,
        OP_POINTER_JUMP,
        OP_DIRECT_JUMP,
        OP_RELATIVE_CALL,
        OP_POINTER_CALL,
        OP_DIRECT_CALL,
        OP_SUB_RETURN,
        OP_INTERRUPT_RETURN,
        OP_EQUAL_SKIP,
        OP_COMPARE,
        OP_COMPARE_CARRY,
        OP_COMPARE_IMM,
        OP_REG_BIT_ZERO_SKIP,
        OP_REG_BIT_ONE_SKIP,
        OP_IO_BIT_ZERO_SKIP,
        OP_IO_BIT_ONE_SKIP,
        OP_FLAG_ONE_BRANCH,
        OP_FLAG_ZERO_BRANCH
    } cbs_op_t;

    typedef enum logic {
        ST_IDLE,
        ST_BUSY
    } cbs_fsm_t;

    typedef struct packed {
        cbs_fsm_t        fsm;
        logic [1:0]      wait_cnt;
        logic [PC_W-1:0] pc;
        logic [7:0]      flags;
        logic [15:0]     prod;
        logic            prod_we;
        logic            push;
        logic [PC_W-1:0] ret_addr;
        logic            pop;
    } cbs_state_t;

endpackage

`default_nettype wire

// File: hw/cbs_compare.sv
// Purpose: subtract-without-store flag generator for the compare family
// Assumes: operands and carry come from the same clock domain
// Notes:   purely combinational, the caller registers the flags
`default_nettype none

module cbs_compare (
    // operands
    input  wire logic [7:0] lhs_i,
    input  wire logic [7:0] rhs_i,
    input  wire logic       use_carry_i,
    input  wire logic       carry_i,
    input  wire logic       zero_i,
    // flags
    output logic            c_o,
    output logic            z_o,
    output logic            n_o,
    output logic            v_o,
    output logic            h_o
);

    logic [8:0] diff;
    logic       borrow_in;

    // with carry the zero flag only survives if it was already set
    always_comb begin
        borrow_in = use_carry_i & carry_i;
        diff      = {1'b0, lhs_i} - {1'b0, rhs_i} - {8'h00, borrow_in};
        c_o       = diff[8];
        n_o       = diff[7];
        v_o       = (lhs_i[7] & ~rhs_i[7] & ~diff[7]) | (~lhs_i[7] & rhs_i[7] & diff[7]);
        h_o       = (~lhs_i[3] & rhs_i[3]) | (rhs_i[3] & diff[3]) | (diff[3] & ~lhs_i[3]);
        z_o       = (diff[7:0] == 8'h00) & (use_carry_i ? zero_i : 1'b1);
    end

endmodule

`default_nettype wire

// File: hw/cbs_frac_mult.sv
// Purpose: fractional 8x8 multiply, signed by signed or signed by unsigned
// Assumes: caller holds the operands stable for the issue cycle
// Notes:   carry is the top product bit before the left shift
`default_nettype none

module cbs_frac_mult (
    // operands
    input  wire logic [7:0]  mcand_i,
    input  wire logic [7:0]  mplier_i,
    input  wire logic        mixed_i,
    // result
    output logic      [15:0] prod_o,
    output logic             c_o,
    output logic             z_o
);

    logic signed [16:0] raw;

    // the second operand is zero-extended in the mixed form
    always_comb begin
        if (mixed_i) begin
            raw = $signed({{9{mcand_i[7]}}, mcand_i}) * $signed({9'h000, mplier_i});
        end else begin
            raw = $signed({{9{mcand_i[7]}}, mcand_i}) * $signed({{9{mplier_i[7]}}, mplier_i});
        end
        prod_o = {raw[14:0], 1'b0};
        c_o    = raw[15];
        z_o    = (prod_o == 16'h0000);
    end

endmodule

`default_nettype wire

// File: hw/cbs_branch_skip.sv
// Purpose: program counter, flag and timing control for branches, skips,
//          calls, returns, compares and fractional multiplies
// Assumes: decoder presents one operation with op_valid_i while ready_o
// Notes:   all effects land at the issue edge, ready_o then stays low for
//          the remaining cycles of the operation
`default_nettype none

// Functional notes
// - fractional multiplies: product shifted, Z C, two cycles
// - relative jump: pc plus offset plus one
// - pointer jump: pc from pointer, two cycles
// - calls push return; timing three, three, four
// - equal skip: skip next when registers equal
// - one-cycle compares update Z N V C H
// - skip when register bit is zero
// - skip when register bit is one
// - I/O bit skips test addressed bit
// - branch if selected flag set, 1/2 cycles
// - branch if selected flag cleared, same timing
// - carry branches follow the carry flag
// - signed branches use N xor V
// - half-carry branches follow H flag
// - user-bit branches follow T flag
// - overflow branches follow V flag
module cbs_branch_skip (
    // clock and reset
    input  wire logic                    mclk_i,
    input  wire logic                    rstn_i,
    // operation from the decoder
    input  wire logic                    op_valid_i,
    input  wire cbs_pkg::cbs_op_t        op_i,
    output logic                         ready_o,
    // operands
    input  wire logic [7:0]              rd_val_i,
    input  wire logic [7:0]              source_operand_i,
    input  wire logic [7:0]              imm_i,
    input  wire logic [cbs_pkg::OFS_W-1:0] offset_i,
    input  wire logic [2:0]              bit_sel_i,
    input  wire logic [7:0]              io_val_i,
    input  wire logic [cbs_pkg::PC_W-1:0] ptr_i,
    input  wire logic [cbs_pkg::PC_W-1:0] target_i,
    input  wire logic                    next_two_i,
    input  wire logic [cbs_pkg::PC_W-1:0] stack_top_i,
    // flag register write from the rest of the core
    input  wire logic                    flags_we_i,
    input  wire logic [7:0]              flags_din_i,
    // state and results
    output logic [cbs_pkg::PC_W-1:0]     program_counter_o,
    output logic [7:0]                   flag_register_o,
    output logic [15:0]                  prod_o,
    output logic                         prod_we_o,
    output logic                         push_o,
    output logic [cbs_pkg::PC_W-1:0]     ret_addr_o,
    output logic                         pop_o
);

    // ************************************************************
    // flag selection
    // ************************************************************

    // the S position is read as N xor V so signed branches do not depend
    // on whether the last flag writer kept S up to date
    function automatic logic flag_pick(input logic [7:0] f, input logic [2:0] sel);
        logic r;
        r = 1'b0;
        unique case (sel)
            3'(cbs_pkg::FLAG_C): r = f[cbs_pkg::FLAG_C];
            3'(cbs_pkg::FLAG_Z): r = f[cbs_pkg::FLAG_Z];
            3'(cbs_pkg::FLAG_N): r = f[cbs_pkg::FLAG_N];
            3'(cbs_pkg::FLAG_V): r = f[cbs_pkg::FLAG_V];
            3'(cbs_pkg::FLAG_S): r = f[cbs_pkg::FLAG_N] ^ f[cbs_pkg::FLAG_V];
            3'(cbs_pkg::FLAG_H): r = f[cbs_pkg::FLAG_H];
            3'(cbs_pkg::FLAG_T): r = f[cbs_pkg::FLAG_T];
            3'(cbs_pkg::FLAG_I): r = f[cbs_pkg::FLAG_I];
        endcase
        return r;
    endfunction

    // ************************************************************
    // arithmetic helpers
    // ************************************************************
    cbs_pkg::cbs_state_t st;
    cbs_pkg::cbs_state_t next_st;

    logic                     accept;
    logic [cbs_pkg::PC_W-1:0] rel_tgt;
    logic [cbs_pkg::PC_W-1:0] skip_tgt;
    logic [2:0]               skip_cyc;
    logic [15:0]              fm_prod;
    logic                     fm_c;
    logic                     fm_z;
    logic                     cmp_c;
    logic                     cmp_z;
    logic                     cmp_n;
    logic                     cmp_v;
    logic                     cmp_h;
    logic                     is_imm;

    assign accept  = op_valid_i && (st.fsm == cbs_pkg::ST_IDLE);
    assign ready_o = (st.fsm == cbs_pkg::ST_IDLE);
    assign is_imm  = (op_i == cbs_pkg::OP_COMPARE_IMM);

    // signed offset is word based; sum wraps inside the 16-bit space
    assign rel_tgt  = st.pc + {{(cbs_pkg::PC_W-cbs_pkg::OFS_W){offset_i[cbs_pkg::OFS_W-1]}},
                               offset_i} + cbs_pkg::PC_STEP;
    // skip length depends on the width of the instruction jumped over
    assign skip_tgt = st.pc + (next_two_i ? cbs_pkg::PC_SKIP2 : cbs_pkg::PC_SKIP1);
    assign skip_cyc = next_two_i ? cbs_pkg::CYC_SKIP2 : cbs_pkg::CYC_SKIP1;

    cbs_frac_mult u_fmul (
        .mcand_i  (rd_val_i),
        .mplier_i (source_operand_i),
        .mixed_i  (op_i == cbs_pkg::OP_FRAC_MULT_MIXED),
        .prod_o   (fm_prod),
        .c_o      (fm_c),
        .z_o      (fm_z)
    );

    cbs_compare u_cmp (
        .lhs_i       (rd_val_i),
        .rhs_i       (is_imm ? imm_i : source_operand_i),
        .use_carry_i (op_i == cbs_pkg::OP_COMPARE_CARRY),
        .carry_i     (st.flags[cbs_pkg::FLAG_C]),
        .zero_i      (st.flags[cbs_pkg::FLAG_Z]),
        .c_o         (cmp_c),
        .z_o         (cmp_z),
        .n_o         (cmp_n),
        .v_o         (cmp_v),
        .h_o         (cmp_h)
    );

    // ************************************************************
    // next state
    // ************************************************************

    // one process decides pc, flags, stack strobes and the busy count
    always_comb begin
        logic [2:0] cyc;
        logic       hit;
        cyc             = cbs_pkg::CYC_ONE;
        hit             = 1'b0;
        next_st         = st;
        next_st.prod_we = 1'b0;
        next_st.push    = 1'b0;
        next_st.pop     = 1'b0;
        // count down the remaining cycles of a multi-cycle operation
        if (st.fsm == cbs_pkg::ST_BUSY) begin
            next_st.wait_cnt = st.wait_cnt - 2'h1;
            if (st.wait_cnt == 2'h1) begin
                next_st.fsm = cbs_pkg::ST_IDLE;
            end
        end
        if (accept) begin
            next_st.pc = st.pc + cbs_pkg::PC_STEP;
            unique case (op_i)
                cbs_pkg::OP_FRAC_MULT_SIGNED,
                cbs_pkg::OP_FRAC_MULT_MIXED: begin
                    next_st.prod                  = fm_prod;
                    next_st.prod_we               = 1'b1;
                    next_st.flags[cbs_pkg::FLAG_C] = fm_c;
                    next_st.flags[cbs_pkg::FLAG_Z] = fm_z;
                    cyc                           = cbs_pkg::CYC_FMUL;
                end
                cbs_pkg::OP_RELATIVE_JUMP: begin
                    next_st.pc = rel_tgt;
                    cyc        = cbs_pkg::CYC_JUMP;
                end
                cbs_pkg::OP_POINTER_JUMP: begin
                    next_st.pc = ptr_i;
                    cyc        = cbs_pkg::CYC_JUMP;
                end
                cbs_pkg::OP_DIRECT_JUMP: begin
                    next_st.pc = target_i;
                    cyc        = cbs_pkg::CYC_DJUMP;
                end
                cbs_pkg::OP_RELATIVE_CALL,
                cbs_pkg::OP_POINTER_CALL: begin
                    next_st.push     = 1'b1;
                    next_st.ret_addr = st.pc + cbs_pkg::PC_STEP;
                    next_st.pc       = (op_i == cbs_pkg::OP_POINTER_CALL) ? ptr_i : rel_tgt;
                    cyc              = cbs_pkg::CYC_CALL;
                end
                cbs_pkg::OP_DIRECT_CALL: begin
                    // the call itself is two words long
                    next_st.push     = 1'b1;
                    next_st.ret_addr = st.pc + cbs_pkg::PC_DSTEP;
                    next_st.pc       = target_i;
                    cyc              = cbs_pkg::CYC_DCALL;
                end
                cbs_pkg::OP_SUB_RETURN,
                cbs_pkg::OP_INTERRUPT_RETURN: begin
                    next_st.pop = 1'b1;
                    next_st.pc  = stack_top_i;
                    cyc         = cbs_pkg::CYC_RETURN;
                    if (op_i == cbs_pkg::OP_INTERRUPT_RETURN) begin
                        next_st.flags[cbs_pkg::FLAG_I] = 1'b1;
                    end
                end
                cbs_pkg::OP_COMPARE,
                cbs_pkg::OP_COMPARE_CARRY,
                cbs_pkg::OP_COMPARE_IMM: begin
                    next_st.flags[cbs_pkg::FLAG_C] = cmp_c;
                    next_st.flags[cbs_pkg::FLAG_Z] = cmp_z;
                    next_st.flags[cbs_pkg::FLAG_N] = cmp_n;
                    next_st.flags[cbs_pkg::FLAG_V] = cmp_v;
                    next_st.flags[cbs_pkg::FLAG_H] = cmp_h;
                end
                cbs_pkg::OP_EQUAL_SKIP:        hit = (rd_val_i == source_operand_i);
                cbs_pkg::OP_REG_BIT_ZERO_SKIP: hit = ~source_operand_i[bit_sel_i];
                cbs_pkg::OP_REG_BIT_ONE_SKIP:  hit = source_operand_i[bit_sel_i];
                cbs_pkg::OP_IO_BIT_ZERO_SKIP:  hit = ~io_val_i[bit_sel_i];
                cbs_pkg::OP_IO_BIT_ONE_SKIP:   hit = io_val_i[bit_sel_i];
                cbs_pkg::OP_FLAG_ONE_BRANCH:   hit = flag_pick(st.flags, bit_sel_i);
                cbs_pkg::OP_FLAG_ZERO_BRANCH:  hit = ~flag_pick(st.flags, bit_sel_i);
            endcase
            // skips and branches only differ in target and taken cost
            if (hit) begin
                if (op_i == cbs_pkg::OP_FLAG_ONE_BRANCH ||
                    op_i == cbs_pkg::OP_FLAG_ZERO_BRANCH) begin
                    next_st.pc = rel_tgt;
                    cyc        = cbs_pkg::CYC_TAKEN;
                end else begin
                    next_st.pc = skip_tgt;
                    cyc        = skip_cyc;
                end
            end
            next_st.wait_cnt = 2'(cyc - 3'h1);
            next_st.fsm      = (cyc > cbs_pkg::CYC_ONE) ? cbs_pkg::ST_BUSY : cbs_pkg::ST_IDLE;
        end else if (flags_we_i) begin
            // core writes only land while no operation is issued
            next_st.flags = flags_din_i;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************

    // reset leaves pc at the vector and all flags clear
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st          <= '0;
            st.fsm      <= cbs_pkg::ST_IDLE;
            st.pc       <= cbs_pkg::PC_RST;
            st.flags    <= cbs_pkg::FLAGS_RST;
        end else begin
            st <= next_st;
        end
    end

    assign program_counter_o = st.pc;
    assign flag_register_o   = st.flags;
    assign prod_o            = st.prod;
    assign prod_we_o         = st.prod_we;
    assign push_o            = st.push;
    assign ret_addr_o        = st.ret_addr;
    assign pop_o             = st.pop;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_busy1;
        !ready_o ##1 ready_o;
    endsequence

    sequence s_busy2;
        !ready_o[*2] ##1 ready_o;
    endsequence

    sequence s_busy3;
        !ready_o[*3] ##1 ready_o;
    endsequence

    a_fmul_result: assert property (
        accept && op_i == cbs_pkg::OP_FRAC_MULT_SIGNED |=>
        prod_we_o && prod_o == $past(fm_prod) && flag_register_o[7:2] == $past(st.flags[7:2])
        ##0 s_busy1)
        else $error("fractional multiply result or timing wrong");

    a_rel_jump_pc: assert property (
        accept && op_i == cbs_pkg::OP_RELATIVE_JUMP |=>
        program_counter_o == $past(rel_tgt) && $stable(flag_register_o) ##0 s_busy1)
        else $error("relative jump target or timing wrong");

    a_ptr_jump_pc: assert property (
        accept && op_i == cbs_pkg::OP_POINTER_JUMP |=>
        program_counter_o == $past(ptr_i) ##0 s_busy1)
        else $error("pointer jump target wrong");

    a_ptr_call_push: assert property (
        accept && op_i == cbs_pkg::OP_POINTER_CALL |=>
        push_o && ret_addr_o == $past(program_counter_o) + cbs_pkg::PC_STEP ##0 s_busy2)
        else $error("pointer call push or timing wrong");

    a_dir_call_time: assert property (
        accept && op_i == cbs_pkg::OP_DIRECT_CALL |=> push_o ##0 s_busy3)
        else $error("direct call timing wrong");

    a_eq_skip_pc: assert property (
        accept && op_i == cbs_pkg::OP_EQUAL_SKIP && rd_val_i == source_operand_i
        && next_two_i |=> program_counter_o == $past(program_counter_o) + 16'h0003 ##0 s_busy2)
        else $error("equal skip over two words wrong");

    a_cmp_flags: assert property (
        accept && op_i == cbs_pkg::OP_COMPARE |=>
        ready_o && flag_register_o[cbs_pkg::FLAG_Z] ==
        ($past(rd_val_i) == $past(source_operand_i)))
        else $error("compare zero flag or timing wrong");

    a_rbit_noskip: assert property (
        accept && op_i == cbs_pkg::OP_REG_BIT_ZERO_SKIP && source_operand_i[bit_sel_i] |=>
        ready_o && program_counter_o == $past(program_counter_o) + cbs_pkg::PC_STEP)
        else $error("bit-clear skip taken on a set bit");

    a_branch_taken: assert property (
        accept && op_i == cbs_pkg::OP_FLAG_ONE_BRANCH && st.flags[bit_sel_i]
        && bit_sel_i != 3'(cbs_pkg::FLAG_S) |=> program_counter_o == $past(rel_tgt) ##0 s_busy1)
        else $error("flag branch not taken as expected");

    a_int_return: assert property (
        accept && op_i == cbs_pkg::OP_INTERRUPT_RETURN |=>
        pop_o && flag_register_o[cbs_pkg::FLAG_I] && program_counter_o == $past(stack_top_i)
        ##0 s_busy3)
        else $error("interrupt return wrong");

endmodule

`default_nettype wire

// File: bench/cbs_branch_skip_tb.sv
// Purpose: self-checking bench for the branch and skip unit
// Assumes: one op offered at a time, each once ready_o is back high
// Notes:   a bench-side pc and flag model gives every expectation
`default_nettype none

module cbs_branch_skip_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // design signals and bench model
    // ************************************************************
    logic             mclk_i, rstn_i, op_valid_i, next_two_i, flags_we_i;
    cbs_pkg::cbs_op_t op_i, eo;
    logic [7:0]       rd_val_i, source_operand_i, imm_i, io_val_i, flags_din_i;
    logic [11:0]      offset_i, ofs;
    logic [2:0]       bit_sel_i, sel;
    logic [15:0]      ptr_i, target_i, stack_top_i, ptr, tgt, stk;
    logic             ready_o, prod_we_o, push_o, pop_o;
    logic [7:0]       flag_register_o, fl, a, b, im, io;
    logic [15:0]      program_counter_o, prod_o, ret_addr_o, pc, ep, xret, xprod;
    logic             two, xpush, xpop, xpwe, tk;
    logic [4:0]       cv;
    logic [15:0]      tv [8];
    int               errors, total_checks, k, ec;

    cbs_branch_skip DUT (.mclk_i, .rstn_i, .op_valid_i, .op_i, .ready_o, .rd_val_i,
        .source_operand_i, .imm_i, .offset_i, .bit_sel_i, .io_val_i, .ptr_i, .target_i,
        .next_two_i, .stack_top_i, .flags_we_i, .flags_din_i, .program_counter_o,
        .flag_register_o, .prod_o, .prod_we_o, .push_o, .ret_addr_o, .pop_o);

    // free-running 125 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    // ************************************************************
    // checking and driving tasks
    // ************************************************************
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // fresh random operands; strobes expected quiet unless a test says so
    task automatic rnd();
        {a, b, im, io} = $urandom;
        {ofs, sel, two} = 16'($urandom);
        {ptr, tgt} = $urandom;
        stk = 16'($urandom);
        {xpush, xpop, xpwe} = 3'h0;
    endtask

    // core write of the flag register, held for exactly one edge
    task automatic set_fl(input logic [7:0] v);
        @(posedge mclk_i);
        flags_we_i  <= 1'b1;
        flags_din_i <= v;
        @(posedge mclk_i);
        flags_we_i <= 1'b0;
        fl = v;
    endtask

    // issue one op, check effects just after the taking edge, then count busy cycles
    task automatic go(input cbs_pkg::cbs_op_t o, input logic [15:0] exp_pc, input int cyc);
        int n;
        @(posedge mclk_i);
        op_valid_i <= 1'b1;
        op_i       <= o;
        {rd_val_i, source_operand_i, imm_i, io_val_i} <= {a, b, im, io};
        {offset_i, bit_sel_i, next_two_i} <= {ofs, sel, two};
        {ptr_i, target_i, stack_top_i} <= {ptr, tgt, stk};
        @(posedge mclk_i);
        op_valid_i <= 1'b0;
        #1;
        n = 1;
        chk_val(program_counter_o, exp_pc, "pc");
        chk_val(16'(flag_register_o), 16'(fl), "flags");
        chk_val(16'({push_o, pop_o, prod_we_o}), 16'({xpush, xpop, xpwe}), "strobes");
        if (xpush) chk_val(ret_addr_o, xret, "return address");
        if (xpwe) chk_val(prod_o, xprod, "product");
        while (ready_o !== 1'b1 && n < 8) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk_val(16'(n), 16'(cyc), "cycles");
        pc = exp_pc;
    endtask

    // ************************************************************
    // expectation functions
    // ************************************************************
    function automatic logic fb(input logic [7:0] f, input logic [2:0] s);
        return (s == 3'h4) ? (f[2] ^ f[3]) : f[s];
    endfunction

    // subtract without store: flags C Z N V H, Z sticky for the carry form
    function automatic logic [7:0] cmp_fl(input logic [7:0] f, x, y, input logic wc);
        logic [8:0] r;
        logic [4:0] h;
        logic       ci;
        ci = wc & f[0];
        r = {1'b0, x} - {1'b0, y} - 9'(ci);
        h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - 5'(ci);
        f[0] = r[8];
        f[1] = (r[7:0] == 8'h00) & (~wc | f[1]);
        f[2] = r[7];
        f[3] = (x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7]);
        f[5] = h[4];
        return f;
    endfunction

    // returns carry then the shifted product
    function automatic logic [16:0] fm(input logic [7:0] x, y, input logic mx);
        logic signed [17:0] p;
        p = $signed({{10{x[7]}}, x}) * $signed({{10{~mx & y[7]}}, y});
        return {p[15], p[14:0], 1'b0};
    endfunction

    // one flag branch; the first 32 use all-clear and all-set flags
    task automatic br(input int i);
        rnd();
        sel = 3'(i);
        if (i < 32) set_fl(i[3] ? 8'hff : 8'h00);
        else set_fl(8'($urandom));
        tk = fb(fl, sel) ^ i[4];
        eo = i[4] ? cbs_pkg::OP_FLAG_ZERO_BRANCH : cbs_pkg::OP_FLAG_ONE_BRANCH;
        ep = pc + 16'h0001 + (tk ? {{4{ofs[11]}}, ofs} : 16'h0000);
        go(eo, ep, tk ? 2 : 1);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {rstn_i, op_valid_i, flags_we_i, next_two_i} = 4'h0;
        op_i = cbs_pkg::OP_COMPARE;
        {rd_val_i, source_operand_i, imm_i, io_val_i, flags_din_i} = '0;
        {offset_i, bit_sel_i, ptr_i, target_i, stack_top_i} = '0;
        {errors, total_checks} = '0;
        pc = cbs_pkg::PC_RST;
        fl = cbs_pkg::FLAGS_RST;
        void'($urandom(32'h0000_569b));
        repeat (20) @(posedge mclk_i);
        rstn_i <= 1'b1;
        #1;
        chk_val(16'({ready_o, flag_register_o}), 16'({1'b1, fl}), "reset state");
        chk_val(program_counter_o, pc, "reset pc");
        $display("test reset done");
        for (int i = 0; i < 32; i++) br(i);
        for (int i = 32; i < 64; i++) br(i);
        $display("test branches done");
        for (int i = 0; i < 50; i++) begin
            rnd();
            // equal operands, and the equal skip once over each instruction length
            if (i < 10) {b, two} = {a, i[0]};
            k = i % 5;
            cv = {io[sel], ~io[sel], b[sel], ~b[sel], a == b};
            ec = cv[k] ? (two ? 3 : 2) : 1;
            eo = (k == 0) ? cbs_pkg::OP_EQUAL_SKIP : cbs_pkg::cbs_op_t'(13 + k);
            go(eo, pc + 16'(ec), ec);
        end
        $display("test skips done");
        for (int i = 0; i < 30; i++) begin
            rnd();
            if (i < 6) {b, im} = {a, a};
            k = i % 3;
            fl = cmp_fl(fl, a, (k == 2) ? im : b, k == 1);
            go(cbs_pkg::cbs_op_t'(11 + k), pc + 16'h0001, 1);
        end
        $display("test compares done");
        for (int i = 0; i < 16; i++) begin
            rnd();
            if (i < 4) {a, b} = {8'h80, i[1] ? 8'h80 : 8'h00};
            {fl[0], xprod} = fm(a, b, i[0]);
            fl[1] = (xprod == 16'h0000);
            xpwe = 1'b1;
            go(cbs_pkg::cbs_op_t'(i[0]), pc + 16'h0001, 2);
        end
        $display("test multiplies done");
        for (int i = 0; i < 24; i++) begin
            rnd();
            k = i % 8;
            ep = pc + {{4{ofs[11]}}, ofs} + 16'h0001;
            tv = '{ep, ptr, tgt, ep, ptr, tgt, stk, stk};
            xpush = (k >= 3 && k <= 5);
            xret = pc + ((k == 5) ? 16'h0002 : 16'h0001);
            xpop = (k >= 6);
            if (k == 7) fl[7] = 1'b1;
            ec = (k < 2) ? 2 : (k < 5) ? 3 : 4;
            go(cbs_pkg::cbs_op_t'(2 + k), tv[k], ec);
        end
        $display("test jumps calls returns done");
        give_verdict();
    end

    // watchdog: the sequence needs under 2000 cycles, ten times that is a hang
    initial begin
        repeat (20000) @(posedge mclk_i);
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end

endmodule

`default_nettype wire
